// *** sbm_pkg.sv ***
// Purpose: Shared constants for the SRAM bus sharing multiplexer
// Assumes: 16-bit data, address bits 23:1, eight input channels
// Notes:   Counts of cycles derive from the 40 MHz system clock
package sbm_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SBM_DATA_W   = 16;
  localparam int SBM_ADDR_W   = 23;
  localparam int SBM_CHAN_N   = 8;
  localparam int SBM_CHAN_W   = 3;
  localparam int SBM_FIFO_D   = 16;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SBM_CLK_MHZ       = 40;
  localparam int SBM_WR_PULSE_NS   = 50;
  localparam int SBM_WR_PULSE_CYC  =
    (SBM_WR_PULSE_NS * SBM_CLK_MHZ + 999) / 1000;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic SBM_SEL_RST     = 1'b0;
  localparam logic SBM_ACTIVE_RST  = 1'b0;
  localparam logic [SBM_ADDR_W-1:0] SBM_PTR_RST = 23'h000000;
  // Controller states, Gray from IDLE through LOAD, WAIT, WRITE and NEXT to DONE
  typedef enum logic [2:0]
  {
    SBM_IDLE  = 3'h0,
    SBM_LOAD  = 3'h1,
    SBM_WAIT  = 3'h3,
    SBM_WRITE = 3'h2,
    SBM_NEXT  = 3'h6,
    SBM_DONE  = 3'h7
  } sbm_state_t;
endpackage

// *** sbm_ram.sv ***
// Purpose: Small word memory with registered read data
// Assumes: One write and one read port on the same clock
// Notes:   No reset on the array, only on the read register
`timescale 1ns/100ps
module sbm_ram
  import sbm_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
)
(
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic [AW-1:0]    i_raddr,
  output logic      [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_r;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Array write, kept out of reset so it maps onto plain storage
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read data
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rdata_r <= '0;
    end
    else
    begin
      rdata_r <= mem[i_raddr];
    end
  end

  assign o_rdata = rdata_r;
endmodule

// *** sbm_fifo.sv ***
// Purpose: Result FIFO with valid and ready on both sides
// Assumes: Read data registered one cycle after the pointer moves
// Notes:   Show-ahead by prefetch into an output register
`timescale 1ns/100ps
module sbm_fifo
  import sbm_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin
      $error("sbm_fifo: DEPTH must be a power of two");
    end
  end

  logic [AW:0]   wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic          pend_r, pend_nxt;   // Read issued, data next cycle
  logic          oval_r, oval_nxt;
  logic [AW:0]   count;
  logic [AW-1:0] raddr;
  logic          push, pop, issue;

  // ----------------------------------------------------------------
  // Pointers and prefetch
  // ----------------------------------------------------------------
  // Count covers stored words not yet moved to the output stage
  always_comb
  begin
    count    = wptr_r - rptr_r;
    // One slot kept back: a write must never hit the word on show
    o_ready  = (count < (AW+1)'(DEPTH - 1));
    push     = i_valid && o_ready;
    pop      = oval_r && i_ready;
    // Issue when the output stage will be free when data lands
    issue    = (count != '0) && !pend_r && (!oval_r || pop);
    wptr_nxt = push  ? wptr_r + 1'b1 : wptr_r;
    rptr_nxt = issue ? rptr_r + 1'b1 : rptr_r;
    pend_nxt = issue;
    oval_nxt = pend_r ? 1'b1 : (pop ? 1'b0 : oval_r);
    // Re-read the word last issued so read data holds still
    raddr    = issue ? rptr_r[AW-1:0] : rptr_r[AW-1:0] - 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      pend_r <= 1'b0;
      oval_r <= 1'b0;
    end
    else
    begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      pend_r <= pend_nxt;
      oval_r <= oval_nxt;
    end
  end

  sbm_ram #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_ram
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_we      (push),
    .i_waddr   (wptr_r[AW-1:0]),
    .i_wdata   (i_data),
    .i_raddr   (raddr),
    .o_rdata   (o_data)
  );

  assign o_valid = oval_r;
endmodule

// *** sbm_top.sv ***
// Purpose: Shares one external SRAM and flash bus between a host
//          and the on-chip converter interface
// Assumes: Host strobes arrive from pins and are not synchronised;
//          result words come from converter logic on this clock
// Notes:   Host pass-through paths are combinational so host cycles
//          keep their own timing; only ownership decisions sync.
`timescale 1ns/100ps
module sbm_top
  import sbm_pkg::*;
#(
  parameter int CHAN_N = SBM_CHAN_N,
  parameter int ADDR_W = SBM_ADDR_W,
  parameter int DATA_W = SBM_DATA_W,
  parameter int FIFO_D = SBM_FIFO_D
)
(
  input  wire logic                     I_CLK_SYS,
  input  wire logic                     I_RESET_N,
  // Converter side: run request, per-channel windows, result stream
  input  wire logic                     I_START,
  input  wire logic [CHAN_N-1:0]        I_CHAN_EN,
  input  wire logic [CHAN_N*ADDR_W-1:0] I_CHAN_START,
  input  wire logic [CHAN_N*ADDR_W-1:0] I_CHAN_HIGH,
  input  wire logic                     I_RESULT_VALID,
  output logic                          O_RESULT_READY,
  input  wire logic [DATA_W-1:0]        I_RESULT_DATA,
  output logic [SBM_CHAN_W-1:0]         O_CHANNEL,
  output logic                          O_BUSY,
  output logic                          O_DONE,
  // Host expansion bus
  input  wire logic [DATA_W-1:0]        I_HOST_DATA_BUS,
  output logic [DATA_W-1:0]             O_HOST_DATA_BUS,
  output logic                          O_HOST_DATA_BUS_OE_N,
  input  wire logic [ADDR_W:1]          I_HOST_ADDRESS_BUS,
  input  wire logic                     I_HOST_FLASH_SELECT_N,
  input  wire logic                     I_HOST_MEM_SELECT_IN_N,
  input  wire logic                     I_HOST_WR_STROBE_IN_N,
  input  wire logic                     I_HOST_RD_STROBE_IN_N,
  // Memory side bus
  input  wire logic [DATA_W-1:0]        I_MEM_DATA,
  output logic [DATA_W-1:0]             O_MEM_DATA,
  output logic                          O_MEM_DATA_OE_N,
  output logic [ADDR_W:1]               O_MEM_ADDRESS,
  output logic                          O_MEM_SELECT_OUT_N,
  output logic                          O_MEM_WR_STROBE_OUT_N,
  output logic                          O_MEM_RD_STROBE_OUT_N,
  output logic                          O_FLASH_SELECT_N
);
  initial
  begin
    if (CHAN_N != SBM_CHAN_N || ADDR_W != SBM_ADDR_W)
    begin
      $error("sbm_top: channel count and address width are fixed");
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sbm_state_t               state_r, state_nxt;
  logic                     mux_sel_r, mux_sel_nxt;
  logic                     converter_active_drive_r;
  logic                     converter_active_drive_nxt;
  logic [ADDR_W-1:0]        result_write_pointer_r;
  logic [ADDR_W-1:0]        result_write_pointer_nxt;
  logic [ADDR_W-1:0]        limit_r, limit_nxt;
  logic [SBM_CHAN_W-1:0]    chan_r, chan_nxt;
  logic [DATA_W-1:0]        result_word_r, result_word_nxt;
  logic [3:0]               pulse_r, pulse_nxt;
  logic                     converter_mem_select_n;
  logic                     converter_wr_n;
  logic                     converter_rd_n;
  logic                     fifo_valid, fifo_ready;
  logic [DATA_W-1:0]        fifo_data;
  logic                     start_s1_r, start_s2_r, start_s3_r;
  logic [CHAN_N-1:0]        en_s1_r, en_s2_r;
  logic                     mem_write_drive;
  logic                     host_read_drive;
  logic                     found;
  logic [SBM_CHAN_W-1:0]    found_chan;

  // Next enabled channel at or after a given index
  function automatic logic [SBM_CHAN_W:0] next_chan
  (
    input logic [CHAN_N-1:0]     en,
    input logic [SBM_CHAN_W-1:0] from
  );
    logic [SBM_CHAN_W:0] res;
    res = '0;
    for (int k = CHAN_N - 1; k >= 0; k--)
    begin
      if (en[k] && k >= int'(from))
      begin
        res = {1'b1, SBM_CHAN_W'(k)};
      end
    end
    return res;
  endfunction

  // Slice one channel's window value out of a packed vector
  function automatic logic [ADDR_W-1:0] chan_field
  (
    input logic [CHAN_N*ADDR_W-1:0] vec,
    input logic [SBM_CHAN_W-1:0]    idx
  );
    return vec[idx*ADDR_W +: ADDR_W];
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Start and channel enables arrive asynchronously from outside; the
  // third start stage only serves edge detection, never the first
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      start_s1_r <= 1'b0;
      start_s2_r <= 1'b0;
      start_s3_r <= 1'b0;
      en_s1_r    <= '0;
      en_s2_r    <= '0;
    end
    else
    begin
      start_s1_r <= I_START;
      start_s2_r <= start_s1_r;
      start_s3_r <= start_s2_r;
      en_s1_r    <= I_CHAN_EN;
      en_s2_r    <= en_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Result FIFO
  // ----------------------------------------------------------------
  // Buffers results so the converter waits on a write pulse only when the FIFO is full
  sbm_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_D)) u_fifo
  (
    .i_clk     (I_CLK_SYS),
    .i_reset_n (I_RESET_N),
    .i_valid   (I_RESULT_VALID),
    .o_ready   (O_RESULT_READY),
    .i_data    (I_RESULT_DATA),
    .o_valid   (fifo_valid),
    .i_ready   (fifo_ready),
    .o_data    (fifo_data)
  );

  // ----------------------------------------------------------------
  // Ownership controller
  // ----------------------------------------------------------------
  // Next state, pointer and ownership
  always_comb
  begin
    state_nxt                  = state_r;
    mux_sel_nxt                = mux_sel_r;
    converter_active_drive_nxt = converter_active_drive_r;
    result_write_pointer_nxt   = result_write_pointer_r;
    limit_nxt                  = limit_r;
    chan_nxt                   = chan_r;
    result_word_nxt            = result_word_r;
    pulse_nxt                  = pulse_r;
    fifo_ready                 = 1'b0;
    {found, found_chan}        = next_chan(en_s2_r, chan_r);
    unique case (state_r)
      SBM_IDLE:
      begin
        chan_nxt = '0;
        if (start_s2_r && !start_s3_r && en_s2_r != '0)
        begin
          state_nxt                  = SBM_LOAD;
          mux_sel_nxt                = 1'b1;
          converter_active_drive_nxt = 1'b1;
        end
      end
      SBM_LOAD:
      begin
        if (found)
        begin
          chan_nxt                 = found_chan;
          result_write_pointer_nxt =
            chan_field(I_CHAN_START, found_chan);
          limit_nxt = chan_field(I_CHAN_HIGH, found_chan);
          state_nxt = SBM_WAIT;
        end
        else
        begin
          state_nxt = SBM_DONE;
        end
      end
      SBM_WAIT:
      begin
        fifo_ready = 1'b1;
        if (fifo_valid)
        begin
          result_word_nxt = fifo_data;
          pulse_nxt       = 4'(SBM_WR_PULSE_CYC);
          state_nxt       = SBM_WRITE;
        end
      end
      SBM_WRITE:
      begin
        // Strobes stay low for the pulse count
        pulse_nxt = pulse_r - 4'h1;
        if (pulse_r == 4'h1)
        begin
          state_nxt = SBM_NEXT;
        end
      end
      SBM_NEXT:
      begin
        // Stop this channel at its upper address
        if (result_write_pointer_r == limit_r)
        begin
          if (chan_r == SBM_CHAN_W'(CHAN_N - 1))
          begin
            state_nxt = SBM_DONE;
          end
          else
          begin
            chan_nxt  = chan_r + 1'b1;
            state_nxt = SBM_LOAD;
          end
        end
        else
        begin
          result_write_pointer_nxt =
            result_write_pointer_r + 1'b1;
          state_nxt = SBM_WAIT;
        end
      end
      SBM_DONE:
      begin
        // Only state where the host regains the bus, apart from reset
        mux_sel_nxt                = 1'b0;
        converter_active_drive_nxt = 1'b0;
        state_nxt                  = SBM_IDLE;
      end
      default:
      begin
        state_nxt = SBM_IDLE;
      end
    endcase
  end

  // Register group; reset hands the bus to the host
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      state_r                  <= SBM_IDLE;
      mux_sel_r                <= SBM_SEL_RST;
      converter_active_drive_r <= SBM_ACTIVE_RST;
      result_write_pointer_r   <= SBM_PTR_RST;
      limit_r                  <= SBM_PTR_RST;
      chan_r                   <= '0;
      result_word_r            <= '0;
      pulse_r                  <= 4'h0;
    end
    else
    begin
      state_r                  <= state_nxt;
      mux_sel_r                <= mux_sel_nxt;
      converter_active_drive_r <= converter_active_drive_nxt;
      result_write_pointer_r   <= result_write_pointer_nxt;
      limit_r                  <= limit_nxt;
      chan_r                   <= chan_nxt;
      result_word_r            <= result_word_nxt;
      pulse_r                  <= pulse_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Converter memory strobes
  // ----------------------------------------------------------------
  // Select, write and read strobes fall together while storing
  always_comb
  begin
    converter_mem_select_n = (state_r != SBM_WRITE);
    converter_wr_n         = (state_r != SBM_WRITE);
    converter_rd_n         = (state_r != SBM_WRITE);
  end

  // ----------------------------------------------------------------
  // Bus multiplexers
  // ----------------------------------------------------------------
  // Host strobes pass straight through so host timing is kept;
  // the SRAM decodes the cycle from select and strobes
  always_comb
  begin
    // Data and address sources
    O_MEM_DATA    = mux_sel_r ? result_word_r : I_HOST_DATA_BUS;
    O_MEM_ADDRESS = mux_sel_r ? result_write_pointer_r
                              : I_HOST_ADDRESS_BUS;
    // Control lines follow the host again once select drops
    O_MEM_SELECT_OUT_N = mux_sel_r ? converter_mem_select_n
                                   : I_HOST_MEM_SELECT_IN_N;
    O_MEM_WR_STROBE_OUT_N = mux_sel_r ? converter_wr_n
                                      : I_HOST_WR_STROBE_IN_N;
    O_MEM_RD_STROBE_OUT_N = mux_sel_r ? converter_rd_n
                                      : I_HOST_RD_STROBE_IN_N;
    O_FLASH_SELECT_N = mux_sel_r ? 1'b1 : I_HOST_FLASH_SELECT_N;
    // Write drive: forced by converter, else host write cycle
    mem_write_drive = converter_active_drive_r
                    || (!I_HOST_WR_STROBE_IN_N
                        && (!I_HOST_FLASH_SELECT_N
                            || !I_HOST_MEM_SELECT_IN_N));
    O_MEM_DATA_OE_N = !mem_write_drive;
    // Host read drive; either region may be read
    host_read_drive = !I_HOST_RD_STROBE_IN_N
                    && (!I_HOST_FLASH_SELECT_N
                        || !I_HOST_MEM_SELECT_IN_N);
    O_HOST_DATA_BUS_OE_N = !host_read_drive;
    O_HOST_DATA_BUS      = I_MEM_DATA;
  end

  // Status toward the converter side
  assign O_CHANNEL = chan_r;
  assign O_BUSY    = mux_sel_r;
  assign O_DONE    = (state_r == SBM_DONE);
endmodule

// *** sbm_top_chk.sv ***
// Purpose: Port-level checks for the bus sharing multiplexer
// Assumes: Bound into sbm_top; a single clock domain
// Notes:   O_BUSY is the shared select seen at the ports
`timescale 1ns/100ps
module sbm_top_chk
  import sbm_pkg::*;
#(
  parameter int ADDR_W = SBM_ADDR_W,
  parameter int DATA_W = SBM_DATA_W
)
(
  input wire logic              I_CLK_SYS,
  input wire logic              I_RESET_N,
  input wire logic [DATA_W-1:0] I_HOST_DATA_BUS,
  input wire logic [ADDR_W:1]   I_HOST_ADDRESS_BUS,
  input wire logic              I_HOST_FLASH_SELECT_N,
  input wire logic              I_HOST_MEM_SELECT_IN_N,
  input wire logic              I_HOST_WR_STROBE_IN_N,
  input wire logic              I_HOST_RD_STROBE_IN_N,
  input wire logic              O_BUSY,
  input wire logic              O_DONE,
  input wire logic              O_HOST_DATA_BUS_OE_N,
  input wire logic [DATA_W-1:0] O_MEM_DATA,
  input wire logic              O_MEM_DATA_OE_N,
  input wire logic [ADDR_W:1]   O_MEM_ADDRESS,
  input wire logic              O_MEM_SELECT_OUT_N,
  input wire logic              O_MEM_WR_STROBE_OUT_N,
  input wire logic              O_MEM_RD_STROBE_OUT_N,
  input wire logic              O_FLASH_SELECT_N
);
  // ------------------------------------------------------------
  // Ownership, strobes and release
  // ------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RESET_N);
  logic host_sel;
  // Either host select low
  assign host_sel = !I_HOST_FLASH_SELECT_N || !I_HOST_MEM_SELECT_IN_N;
  chk_addr_host:
    assert property (!O_BUSY |-> O_MEM_ADDRESS == I_HOST_ADDRESS_BUS)
    else $error("memory address not from host");
  chk_data_host:
    assert property (!O_BUSY |-> O_MEM_DATA == I_HOST_DATA_BUS)
    else $error("memory data not from host");
  chk_drive_busy:
    assert property (O_BUSY |-> !O_MEM_DATA_OE_N)
    else $error("memory data not driven while busy");
  chk_drive_host:
    assert property (!O_BUSY |->
      O_MEM_DATA_OE_N == !(!I_HOST_WR_STROBE_IN_N && host_sel))
    else $error("memory data drive wrong for host");
  chk_host_read:
    assert property (O_HOST_DATA_BUS_OE_N ==
      !(!I_HOST_RD_STROBE_IN_N && host_sel))
    else $error("host data drive wrong");
  chk_ctl_follow:
    assert property (!O_BUSY |->
      O_MEM_SELECT_OUT_N == I_HOST_MEM_SELECT_IN_N &&
      O_MEM_WR_STROBE_OUT_N == I_HOST_WR_STROBE_IN_N &&
      O_MEM_RD_STROBE_OUT_N == I_HOST_RD_STROBE_IN_N &&
      O_FLASH_SELECT_N == I_HOST_FLASH_SELECT_N)
    else $error("memory controls not from host");
  chk_store_joint:
    assert property (O_BUSY && !O_MEM_WR_STROBE_OUT_N |->
      !O_MEM_SELECT_OUT_N && !O_MEM_RD_STROBE_OUT_N)
    else $error("store strobes not low together");
  chk_pulse_len:
    assert property (O_BUSY && $fell(O_MEM_WR_STROBE_OUT_N) |=>
      !O_MEM_WR_STROBE_OUT_N ##1 O_MEM_WR_STROBE_OUT_N)
    else $error("store pulse length wrong");
  chk_done_drop:
    assert property (O_DONE |=> !O_BUSY)
    else $error("busy stays after done");
  chk_drop_done:
    assert property ($fell(O_BUSY) |-> $past(O_DONE))
    else $error("busy fell outside completion");
endmodule
bind sbm_top sbm_top_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N),
  .I_HOST_DATA_BUS(I_HOST_DATA_BUS),
  .I_HOST_ADDRESS_BUS(I_HOST_ADDRESS_BUS),
  .I_HOST_FLASH_SELECT_N(I_HOST_FLASH_SELECT_N),
  .I_HOST_MEM_SELECT_IN_N(I_HOST_MEM_SELECT_IN_N),
  .I_HOST_WR_STROBE_IN_N(I_HOST_WR_STROBE_IN_N),
  .I_HOST_RD_STROBE_IN_N(I_HOST_RD_STROBE_IN_N),
  .O_BUSY(O_BUSY), .O_DONE(O_DONE),
  .O_HOST_DATA_BUS_OE_N(O_HOST_DATA_BUS_OE_N),
  .O_MEM_DATA(O_MEM_DATA), .O_MEM_DATA_OE_N(O_MEM_DATA_OE_N),
  .O_MEM_ADDRESS(O_MEM_ADDRESS),
  .O_MEM_SELECT_OUT_N(O_MEM_SELECT_OUT_N),
  .O_MEM_WR_STROBE_OUT_N(O_MEM_WR_STROBE_OUT_N),
  .O_MEM_RD_STROBE_OUT_N(O_MEM_RD_STROBE_OUT_N),
  .O_FLASH_SELECT_N(O_FLASH_SELECT_N));

// *** sbm_sram_model.sv ***
// Purpose: Behavioural word SRAM on the memory side
// Assumes: Sampled on the system clock; sparse contents
// Notes:   Undriven read data toggles so stale values never match
`timescale 1ns/100ps
module sbm_sram_model
(
  input  wire logic        i_clk,
  input  wire logic [23:1] i_addr,
  input  wire logic        i_sel_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_rd_n,
  input  wire logic [15:0] i_data,
  input  wire logic        i_oe_n,
  output logic      [15:0] o_data,
  output logic      [15:0] o_wr_cnt
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [15:0] mem [int];
  logic        wr_prev;
  initial
  begin
    o_data = 16'h0000;
    o_wr_cnt = 16'h0000;
    wr_prev = 1'b0;
  end
  // Write on select and strobe; undriven bus stores garbage
  always @(posedge i_clk)
  begin
    if (!i_sel_n && !i_wr_n)
    begin
      mem[int'(i_addr)] = i_oe_n ? ~i_data : i_data;
      if (!wr_prev)
        o_wr_cnt = o_wr_cnt + 16'h0001;
    end
    wr_prev = !i_sel_n && !i_wr_n;
    // Read only with select and read strobe, never during a write
    if (!i_sel_n && !i_rd_n && i_wr_n && mem.exists(int'(i_addr)))
      o_data <= mem[int'(i_addr)];
    else
      o_data <= ~o_data;
  end
endmodule

// *** test_sram_bus_sharing_mux.sv ***
// Purpose: Self-checking bench for the bus sharing multiplexer
// Assumes: Inputs change at the falling clock edge
// Notes:   Results pass through the 16-word FIFO before storing
`timescale 1ns/100ps
module test_sram_bus_sharing_mux
  import sbm_pkg::*;
;
  logic clk, rst_n, start, rvalid, rready, busy, done;
  logic fl_n, sl_n, wr_n, rd_n, hoe_n, moe_n, msel_n, mwr_n, mrd_n, mfl_n;
  logic [7:0] chan_en;
  logic [183:0] chan_lo, chan_hi;
  logic [15:0] rdata, hdata, hq, mdata, mq, wcnt, w0, q;
  logic [SBM_ADDR_W:1] haddr, maddr;
  logic [2:0] chan;
  int n_mismatch, total_checks, cyc;
  // ------------------------------------------------------------
  // Clock, reset, instances
  // ------------------------------------------------------------
  always #12.5 clk = ~clk;
  sbm_top DUT (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_START(start),
    .I_CHAN_EN(chan_en), .I_CHAN_START(chan_lo), .I_CHAN_HIGH(chan_hi),
    .I_RESULT_VALID(rvalid), .O_RESULT_READY(rready),
    .I_RESULT_DATA(rdata), .O_CHANNEL(chan), .O_BUSY(busy),
    .O_DONE(done), .I_HOST_DATA_BUS(hdata), .O_HOST_DATA_BUS(hq),
    .O_HOST_DATA_BUS_OE_N(hoe_n), .I_HOST_ADDRESS_BUS(haddr),
    .I_HOST_FLASH_SELECT_N(fl_n), .I_HOST_MEM_SELECT_IN_N(sl_n),
    .I_HOST_WR_STROBE_IN_N(wr_n), .I_HOST_RD_STROBE_IN_N(rd_n),
    .I_MEM_DATA(mq), .O_MEM_DATA(mdata), .O_MEM_DATA_OE_N(moe_n),
    .O_MEM_ADDRESS(maddr), .O_MEM_SELECT_OUT_N(msel_n),
    .O_MEM_WR_STROBE_OUT_N(mwr_n), .O_MEM_RD_STROBE_OUT_N(mrd_n),
    .O_FLASH_SELECT_N(mfl_n));
  sbm_sram_model u_mem (.i_clk(clk), .i_addr(maddr), .i_sel_n(msel_n),
    .i_wr_n(mwr_n), .i_rd_n(mrd_n), .i_data(mdata), .i_oe_n(moe_n),
    .o_data(mq), .o_wr_cnt(wcnt));
  // Ceiling far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Host strobes held over two edges, then all released high
  task automatic host_op(input logic f, s, w, r,
                         input logic [SBM_ADDR_W:1] a,
                         input logic [15:0] d, output logic [15:0] o);
    @(negedge clk);
    {fl_n, sl_n, wr_n, rd_n, haddr, hdata} = {f, s, w, r, a, d};
    repeat (2) @(posedge clk);
    #1;
    check(moe_n, !(!w && (!f || !s)));
    check(hoe_n, !(!r && (!f || !s)));
    check({maddr, mdata}, {a, d});
    check({msel_n, mwr_n, mrd_n, mfl_n}, {s, w, r, f});
    o = hq;
    @(negedge clk);
    {fl_n, sl_n, wr_n, rd_n} = 4'hF;
  endtask
  task automatic set_win(input int k, input logic [22:0] lo, hi);
    chan_en[k] = 1'b1;
    chan_lo[k*23+:23] = lo;
    chan_hi[k*23+:23] = hi;
  endtask
  // Valid held until ready is seen high at a rising edge
  task automatic push(input logic [15:0] w);
    int k;
    @(negedge clk);
    rvalid = 1'b1;
    rdata = w;
    k = 0;
    while (rready !== 1'b1 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    rvalid = 1'b0;
  endtask
  task automatic go();
    @(negedge clk);
    start = 1'b1;
  endtask
  task automatic finish_run();
    int k;
    k = 0;
    while (done !== 1'b1 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    check(busy, 1'b1);
    @(negedge clk);
    check({busy, done}, 2'b00);
    start = 1'b0;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_host();
    // SRAM write and read at 0x123, flash write at 0x456, then an unselected cycle
    host_op(1, 0, 0, 1, 23'h000123, 16'hA5C3, q);
    host_op(0, 1, 0, 1, 23'h000456, 16'h5A3C, q);
    host_op(1, 0, 1, 0, 23'h000123, 16'h0F0F, q);
    check(q, 16'hA5C3);
    host_op(1, 1, 0, 0, 23'h7FFFFF, 16'hFFFF, q);
  endtask
  // Fill FIFO to refusal, then one run across two windows
  task automatic t_fill();
    w0 = wcnt;
    chan_en = 8'h00;
    set_win(0, 23'h000000, 23'h000009);
    set_win(3, 23'h000040, 23'h000045);
    for (int i = 0; i < SBM_FIFO_D; i++)
      push(16'h1000 + i[15:0]);
    check(rready, 1'b0);
    go();
    finish_run();
    check(rready, 1'b1);
    for (int i = 0; i < 16; i++)
      check(u_mem.mem[i < 10 ? i : 16'h0036 + i], 16'h1000 + i[15:0]);
    check(u_mem.mem.exists(10) || u_mem.mem.exists(16'h46), 0);
    check(wcnt - w0, 16'h0010);
  endtask
  // Slow producer, host meddling and a second start while busy
  task automatic t_stall();
    int k;
    w0 = wcnt;
    chan_en = 8'h00;
    set_win(7, 23'h7FFFFD, 23'h7FFFFF);
    go();
    k = 0;
    while (busy !== 1'b1 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    {sl_n, wr_n, haddr} = {2'b00, 23'h000123};
    @(negedge clk);
    check({chan, maddr, moe_n, mfl_n}, {3'h7, 23'h7FFFFD, 2'b01});
    {sl_n, wr_n, start} = 3'h6;
    for (int i = 0; i < 3; i++)
    begin
      repeat (4) @(negedge clk);
      start = 1'b1;
      push(16'hC000 + i[15:0]);
    end
    finish_run();
    for (int i = 0; i < 3; i++)
      check(u_mem.mem[23'h7FFFFD + i], 16'hC000 + i[15:0]);
    check(u_mem.mem.exists(23'h7FFFFC), 0);
    check(wcnt - w0, 16'h0003);
  endtask
  // Reset in mid-run hands the bus straight back
  task automatic t_abort();
    chan_en = 8'h00;
    set_win(0, 23'h000000, 23'h000003);
    go();
    push(16'hBEEF);
    repeat (2) @(negedge clk);
    check(busy, 1'b1);
    rst_n = 1'b0;
    @(negedge clk);
    check({busy, done, rready}, 3'b001);
    check({msel_n, moe_n}, 2'b11);
    start = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    host_op(1, 0, 1, 0, 23'h000123, 16'h0000, q);
    check(q, 16'hA5C3);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {clk, rst_n, start, rvalid, fl_n, sl_n, wr_n, rd_n} = 8'h0F;
    {chan_en, chan_lo, chan_hi, rdata, hdata, haddr} = '0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    check({busy, done, rready}, 3'b001);
    t_host();
    t_fill();
    t_stall();
    t_abort();
    print_verdict();
  end
endmodule
